// ---- verilog/cog_pkg.sv ----
// package: register map, field layout, reset values and shared types of the output gating block
package cog_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_PAIRS = 6;
  localparam int ADDR_W = 7;

  // ==========================================================================
  // register byte addresses
  localparam logic [7:0] ADDR_PAIR_EN = 8'h00;
  localparam logic [7:0] ADDR_REF_CTRL = 8'h04;
  localparam logic [7:0] ADDR_DIS_STATE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ==========================================================================
  // field positions
  localparam int REF_EN_BIT = 4;
  localparam int REF_KEEP_BIT = 5;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ADDR_LSB = 2;
  localparam int ST_RUN_LSB = 9;
  localparam int ST_REFRUN_BIT = 15;
  localparam int ST_REFOE_BIT = 16;

  // ==========================================================================
  // reset values
  localparam logic [5:0] RST_PAIR_EN = 6'h3F;
  localparam logic RST_REF_EN = 1'b1;
  localparam logic RST_REF_KEEP = 1'b0;
  localparam logic [1:0] RST_DIS_STATE = 2'h0;

  // bus addresses picked by the address strap
  localparam logic [6:0] BUS_ADDR_STRAP0 = 7'b1101000;
  localparam logic [6:0] BUS_ADDR_STRAP1 = 7'b1101010;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MODE_UNSTARTED = 2'b00,
    MODE_POWERDOWN = 2'b01,
    MODE_WAKE = 2'b10,
    MODE_ACTIVE = 2'b11
  } cog_mode_type;

  // board pins as one bundle, before and after synchronising
  typedef struct packed {
    logic powerdownN;
    logic busAddressStrap;
    logic [NUM_PAIRS-1:0] pairEnablePinN;
  } cog_pins_type;

  localparam int PINS_W = $bits(cog_pins_type);

endpackage : cog_pkg

// ---- verilog/cog_sync.sv ----
// module: two flip-flop synchroniser for a bundle of board pins
`timescale 1ns/1ps
`default_nettype none

module cog_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================================
  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end else if (clkEn) begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;

endmodule : cog_sync

`default_nettype wire

// ---- verilog/cog_output_gating.sv ----
// module: power-down and per-pair output gating of the clock generator, with an ahb-lite slave
`timescale 1ns/1ps
`default_nettype none

module cog_output_gating (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // board pins
  input wire logic powerdown_n,
  input wire logic [cog_pkg::NUM_PAIRS-1:0] pair_enable_pin_n,
  input wire logic bus_address_strap,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // clock outputs and bus address
  output logic [cog_pkg::NUM_PAIRS-1:0] diff_clock_true,
  output logic [cog_pkg::NUM_PAIRS-1:0] diff_clock_comp,
  output logic refOut,
  output logic refOutOe_n,
  output logic [cog_pkg::ADDR_W-1:0] busAddress
);

  localparam int NP = cog_pkg::NUM_PAIRS;

  // ==========================================================================
  // pin synchronisers
  cog_pkg::cog_pins_type pinsRaw;
  cog_pkg::cog_pins_type pins;
  logic [cog_pkg::PINS_W-1:0] pinsSyncBits;

  assign pinsRaw.powerdownN = powerdown_n;
  assign pinsRaw.busAddressStrap = bus_address_strap;
  assign pinsRaw.pairEnablePinN = pair_enable_pin_n;

  // reset value: powered down, pins disabling, so nothing starts before the pins are seen
  cog_sync #(
    .WIDTH(cog_pkg::PINS_W),
    .RESET_VALUE({1'b0, 1'b0, {NP{1'b1}}})
  ) u_pinSync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .asyncIn(pinsRaw),
    .syncOut(pinsSyncBits)
  );

  assign pins = cog_pkg::cog_pins_type'(pinsSyncBits);

  // ==========================================================================
  // software registers
  logic [NP-1:0] pairBusEn_q;
  logic refEnable_q;
  logic refKeepAlive_q;
  logic [1:0] disStateSel_q;

  // ==========================================================================
  // ahb-lite address and data phase
  logic addrPhase;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdData_q;
  logic [31:0] rdSel;
  logic [31:0] statusWord;
  logic wrPairEn;
  logic wrRefCtrl;
  logic wrDisState;

  // zero wait states; a frozen block holds the bus off instead of losing a transfer
  assign hreadyout = clkEn;
  assign hresp = 1'b0;
  assign hrdata = rdData_q;
  assign addrPhase = hsel && htrans[cog_pkg::HTRANS_ACTIVE_BIT] && hready;

  // write strobes decoded from the latched address
  assign wrPairEn = wrPend_q && (wrAddr_q == cog_pkg::ADDR_PAIR_EN);
  assign wrRefCtrl = wrPend_q && (wrAddr_q == cog_pkg::ADDR_REF_CTRL);
  assign wrDisState = wrPend_q && (wrAddr_q == cog_pkg::ADDR_DIS_STATE);

  // read mux; unmapped addresses read zero
  assign rdSel =
    (haddr == cog_pkg::ADDR_PAIR_EN) ? {26'h0000000, pairBusEn_q} :
    (haddr == cog_pkg::ADDR_REF_CTRL) ? {26'h0000000, refKeepAlive_q, refEnable_q, 4'h0} :
    (haddr == cog_pkg::ADDR_DIS_STATE) ? {30'h00000000, disStateSel_q} :
    (haddr == cog_pkg::ADDR_STATUS) ? statusWord :
    32'h00000000;

  // bus phase tracking
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdData_q <= 32'h00000000;
    end else if (clkEn) begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr;
      end
      if (addrPhase && !hwrite) begin
        rdData_q <= rdSel;
      end
    end
  end

  // register writes land in the data phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pairBusEn_q <= cog_pkg::RST_PAIR_EN;
      refEnable_q <= cog_pkg::RST_REF_EN;
      refKeepAlive_q <= cog_pkg::RST_REF_KEEP;
      disStateSel_q <= cog_pkg::RST_DIS_STATE;
    end else if (clkEn) begin
      if (wrPairEn) pairBusEn_q <= hwdata[NP-1:0];
      if (wrRefCtrl) refEnable_q <= hwdata[cog_pkg::REF_EN_BIT];
      if (wrRefCtrl) refKeepAlive_q <= hwdata[cog_pkg::REF_KEEP_BIT];
      if (wrDisState) disStateSel_q <= hwdata[1:0];
    end
  end

  // ==========================================================================
  // power mode state machine
  cog_pkg::cog_mode_type mode_q;
  cog_pkg::cog_mode_type mode_d;
  logic strapSel_q;
  logic firstHigh;

  assign firstHigh = (mode_q == cog_pkg::MODE_UNSTARTED) && pins.powerdownN;

  // only the first high starts; later highs just leave power-down
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      cog_pkg::MODE_UNSTARTED: begin
        if (pins.powerdownN) mode_d = cog_pkg::MODE_ACTIVE;
      end
      cog_pkg::MODE_POWERDOWN, cog_pkg::MODE_WAKE, cog_pkg::MODE_ACTIVE: begin
        if (pins.powerdownN) begin
          mode_d = cog_pkg::MODE_ACTIVE;
        end else if (refKeepAlive_q) begin
          mode_d = cog_pkg::MODE_WAKE;
        end else begin
          mode_d = cog_pkg::MODE_POWERDOWN;
        end
      end
    endcase
  end

  // strap caught on the start edge, never under reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_q <= cog_pkg::MODE_UNSTARTED;
      strapSel_q <= 1'b0;
    end else if (clkEn) begin
      mode_q <= mode_d;
      if (firstHigh) strapSel_q <= pins.busAddressStrap;
    end
  end

  assign busAddress = strapSel_q ? cog_pkg::BUS_ADDR_STRAP1 : cog_pkg::BUS_ADDR_STRAP0;

  // ==========================================================================
  // gating decisions from synchronised pins and registers
  logic started;
  logic [NP-1:0] pairRun;
  logic refRunNext;
  logic refOeNext;

  assign started = (mode_q != cog_pkg::MODE_UNSTARTED);
  // an enable pin is active low
  assign pairRun = {NP{pins.powerdownN && started}} & pairBusEn_q & ~pins.pairEnablePinN;
  // with powerdown high, a cleared bus enable bit hands the reference to the enable bit
  assign refRunNext = !started ? 1'b0 :
                      pins.powerdownN ? ((&pairBusEn_q) || refEnable_q) :
                      refKeepAlive_q;
  assign refOeNext = started;

  // ==========================================================================
  // output clock phase and registered outputs
  logic phase_q;
  logic [NP-1:0] runPair_q;
  logic refRun_q;
  logic refOe_q;
  logic [NP-1:0] trueNext;
  logic [NP-1:0] compNext;

  // stopped pairs drive the programmed level pair
  assign trueNext = (pairRun & {NP{~phase_q}}) | (~pairRun & {NP{disStateSel_q[1]}});
  assign compNext = (pairRun & {NP{phase_q}}) | (~pairRun & {NP{disStateSel_q[0]}});

  // a pair starts and stops only at a phase boundary, so no runt pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
      runPair_q <= '0;
      diff_clock_true <= '0;
      diff_clock_comp <= '0;
      refRun_q <= 1'b0;
      refOe_q <= 1'b0;
      refOut <= 1'b0;
    end else if (clkEn) begin
      phase_q <= ~phase_q;
      runPair_q <= pairRun;
      diff_clock_true <= trueNext;
      diff_clock_comp <= compNext;
      refRun_q <= refRunNext;
      refOe_q <= refOeNext;
      refOut <= refRunNext && ~phase_q; // disabled reference drives low
    end
  end

  assign refOutOe_n = ~refOe_q;

  // status word for software
  assign statusWord = {15'h0000, refOe_q, refRun_q, runPair_q, busAddress, mode_q};

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_pairRunGate;
    clkEn && !pins.powerdownN |=> runPair_q == '0;
  endproperty
  a_pairRunGate: assert property (p_pairRunGate) else $error("pair ran in power-down");

  property p_pairRunCause;
    clkEn && pairRun[0] |=> runPair_q[0] && (diff_clock_comp[0] == ~diff_clock_true[0]);
  endproperty
  a_pairRunCause: assert property (p_pairRunCause) else $error("running pair not toggling");

  property p_disLevel;
    clkEn && !pairRun[1] |=> diff_clock_true[1] == $past(disStateSel_q[1])
      && diff_clock_comp[1] == $past(disStateSel_q[0]);
  endproperty
  a_disLevel: assert property (p_disLevel) else $error("stopped pair wrong level");

  property p_hizBeforeStart;
    (mode_q == cog_pkg::MODE_UNSTARTED) ##1 (mode_q == cog_pkg::MODE_UNSTARTED) |-> refOutOe_n;
  endproperty
  a_hizBeforeStart: assert property (p_hizBeforeStart) else $error("reference driven early");

  property p_refPowerdown;
    clkEn && started && !pins.powerdownN && !refKeepAlive_q |=> !refRun_q && !refOut;
  endproperty
  a_refPowerdown: assert property (p_refPowerdown) else $error("reference kept in power-down");

  property p_refPinDis;
    clkEn && started && pins.powerdownN && (&pairBusEn_q) && pins.pairEnablePinN[2] |=> refRun_q;
  endproperty
  a_refPinDis: assert property (p_refPinDis) else $error("reference stopped by pin");

  property p_refFollowsEn;
    clkEn && started && pins.powerdownN && !(&pairBusEn_q) |=> refRun_q == $past(refEnable_q);
  endproperty
  a_refFollowsEn: assert property (p_refFollowsEn) else $error("reference ignores enable bit");

  property p_wakeMode;
    (mode_q == cog_pkg::MODE_WAKE) && clkEn && !pins.powerdownN && refKeepAlive_q
      |=> runPair_q == '0 && refRun_q;
  endproperty
  a_wakeMode: assert property (p_wakeMode) else $error("wake mode outputs wrong");

  property p_strapHeld;
    started && $stable(mode_q) |=> $stable(strapSel_q);
  endproperty
  a_strapHeld: assert property (p_strapHeld) else $error("strap changed after start");

  // a low enable must freeze every registered output, bus data included
  property p_freeze;
    !clkEn |=> $stable(diff_clock_true) && $stable(diff_clock_comp) && $stable(refOut)
      && $stable(refOutOe_n) && $stable(hrdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");

  c_start: cover property (firstHigh && clkEn);
  c_wake: cover property (mode_q == cog_pkg::MODE_WAKE);
  c_powerdown: cover property (mode_q == cog_pkg::MODE_POWERDOWN);
  c_pinDisable: cover property (pins.powerdownN && started && pins.pairEnablePinN[0]);
  c_busWrite: cover property (wrRefCtrl && clkEn);

endmodule : cog_output_gating

`default_nettype wire

// ---- dv/cog_board_model.sv ----
// board model: drives the powerdown, per-pair enable and strap pins from bench requests
`timescale 1ns/1ps
`default_nettype none

module cog_board_model (
  input wire logic core_clk,
  input wire logic pdReq,
  input wire logic strapReq,
  input wire logic [cog_pkg::NUM_PAIRS-1:0] pinOff,
  output logic powerdown_n,
  output logic bus_address_strap,
  output logic [cog_pkg::NUM_PAIRS-1:0] pair_enable_pin_n
);
  // ==========================================================================
  // pins move just after an edge; no glitches, the device must still resync them
  // pins are unknown until the first edge, well inside the device reset
  always @(posedge core_clk) begin
    powerdown_n <= pdReq;
    bus_address_strap <= strapReq;
    pair_enable_pin_n <= pinOff;
  end
endmodule : cog_board_model
`default_nettype wire

// ---- dv/tb_cog_output_gating.sv ----
// testbench: ahb-lite register access and output gating checks of the clock generator
`timescale 1ns/1ps
`default_nettype none

module tb_cog_output_gating;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] rd;
  wire logic hreadyout, hresp, refOut, refOutOe_n, powerdown_n, bus_address_strap;
  wire logic [31:0] hrdata;
  wire logic [5:0] dTrue, dComp, pinN;
  wire logic [6:0] busAddress;
  logic pdReq = 1'b0;
  logic strapReq = 1'b1;
  logic [5:0] pinOff = 6'h00;
  // bench shadow of the programmed state
  logic [5:0] busEn = 6'h3F;
  logic refEn = 1'b1;
  logic keep = 1'b0;
  logic [1:0] ds = 2'h0;
  logic [5:0] t0, t1, c1;
  logic r0, r1;
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  cog_output_gating i_cog_output_gating (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .powerdown_n(powerdown_n), .pair_enable_pin_n(pinN), .bus_address_strap(bus_address_strap),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .diff_clock_true(dTrue), .diff_clock_comp(dComp), .refOut(refOut),
    .refOutOe_n(refOutOe_n), .busAddress(busAddress));
  cog_board_model i_cog_board_model (.core_clk(core_clk), .pdReq(pdReq), .strapReq(strapReq),
    .pinOff(pinOff), .powerdown_n(powerdown_n), .bus_address_strap(bus_address_strap),
    .pair_enable_pin_n(pinN));

  // ==========================================================================
  // clock and hang guard; the whole run is about 120 cycles
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      final_report();
    end
  end

  // ==========================================================================
  // compare, verdict and bus tasks
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task final_report;
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // address phase held until hready, then data phase held until hready
  task ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    hsel <= 1'b0;
  endtask : ahb_xfer

  task settle;
    repeat (6) @(posedge core_clk);
  endtask : settle

  // expected outputs worked out from the pins and the shadow registers
  task chk_outs;
    logic [5:0] run;
    logic refRun;
    logic [1:0] mode;
    run = pdReq ? (busEn & ~pinOff) : 6'h00;
    refRun = pdReq ? ((&busEn) | refEn) : keep;
    mode = pdReq ? 2'h3 : (keep ? 2'h2 : 2'h1);
    @(posedge core_clk);
    t0 = dTrue;
    r0 = refOut;
    @(posedge core_clk);
    t1 = dTrue;
    c1 = dComp;
    r1 = refOut;
    for (int i = 0; i < 6; i++) begin
      if (run[i]) begin
        chk("pair toggle", {31'h0, ~t0[i]}, {31'h0, t1[i]});
        chk("pair comp", {31'h0, ~t1[i]}, {31'h0, c1[i]});
      end else begin
        chk("pair level", {30'h0, ds}, {30'h0, t1[i], c1[i]});
      end
    end
    if (refRun) chk("ref toggle", {31'h0, ~r0}, {31'h0, r1});
    else chk("ref off", 32'h0, {31'h0, r1});
    chk("ref oe", 32'h0, {31'h0, refOutOe_n});
    ahb_xfer(1'b0, cog_pkg::ADDR_STATUS, 32'h0);
    chk("status", {15'h0, 1'b1, refRun, run, cog_pkg::BUS_ADDR_STRAP1, mode}, rd);
  endtask : chk_outs

  // ==========================================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    ahb_xfer(1'b0, cog_pkg::ADDR_PAIR_EN, 32'h0);
    chk("pair enable reset", 32'h0000003F, rd);
    ahb_xfer(1'b0, cog_pkg::ADDR_REF_CTRL, 32'h0);
    chk("ref control reset", 32'h00000010, rd);
    ahb_xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    ahb_xfer(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h00000000, rd);
    ahb_xfer(1'b0, cog_pkg::ADDR_STATUS, 32'h0);
    chk("status unstarted", {23'h0, cog_pkg::BUS_ADDR_STRAP0, 2'h0}, rd);
    chk("ref hiz", 32'h1, {31'h0, refOutOe_n});
    // first start with strap high and pair 2 disabled by its pin
    pinOff <= 6'h04;
    pdReq <= 1'b1;
    settle();
    chk("bus address", {25'h0, cog_pkg::BUS_ADDR_STRAP1}, {25'h0, busAddress});
    chk_outs();
    ahb_xfer(1'b1, cog_pkg::ADDR_DIS_STATE, 32'h2);
    ds = 2'h2;
    ahb_xfer(1'b1, cog_pkg::ADDR_PAIR_EN, 32'h3E);
    busEn = 6'h3E;
    ahb_xfer(1'b1, cog_pkg::ADDR_REF_CTRL, 32'h0);
    refEn = 1'b0;
    settle();
    chk_outs();
    ahb_xfer(1'b1, cog_pkg::ADDR_REF_CTRL, 32'h10);
    refEn = 1'b1;
    settle();
    chk_outs();
    // power down with keep-alive clear, strap moved to low meanwhile
    strapReq <= 1'b0;
    pdReq <= 1'b0;
    settle();
    chk_outs();
    ahb_xfer(1'b1, cog_pkg::ADDR_REF_CTRL, 32'h30);
    keep = 1'b1;
    settle();
    chk_outs();
    // a later wake keeps the strap latched at first start
    pdReq <= 1'b1;
    pinOff <= 6'h00;
    settle();
    chk_outs();
    chk("address kept", {25'h0, cog_pkg::BUS_ADDR_STRAP1}, {25'h0, busAddress});
    // freeze: running pairs and the bus stall while the enable is low
    clkEn <= 1'b0;
    @(posedge core_clk);
    t0 = dTrue;
    r0 = refOut;
    repeat (3) @(posedge core_clk);
    chk("frozen pairs", {26'h0, t0}, {26'h0, dTrue});
    chk("frozen ref", {31'h0, r0}, {31'h0, refOut});
    chk("frozen ready", 32'h0, {31'h0, hreadyout});
    clkEn <= 1'b1;
    settle();
    chk_outs();
    final_report();
  end
endmodule : tb_cog_output_gating
`default_nettype wire
